// ===== mcg_config.v
// Behaviour
// (R1) supported-group field resets to 0x1f, meaning field plus one groups.
// (R2) at most 64 groups; the field is locked and only the loader may set it.
// (R3) capability bit 15 reports ecrc regeneration, resets to one, locked.
// (R4) multicast acts only while control bit 15 is set; it resets to zero.
// (R5) while on, enabled groups equal the six-bit count field plus one.
// (R6) software keeps the enabled count at or below the supported count.
// (R7) the index field picks the address bit where the group number starts.
// (R8) software keeps the index at 12 or more while multicast is on.
// (R9) low base holds window address bits 31:12; bits 11:6 read zero.
// (R10) high base holds window address bits 63:32.
// (R11) software leaves base bits in or below the group field at zero.
// (R12) low receive mask bit n stands for group n, groups 0 to 31.
// (R13) a tlp is sent out when on the bus, enabled and masked, not from here.
// (R14) mask bits for groups above the enabled count are disregarded.
// (R15) the high receive mask covers groups 32 to 63, bit 0 is group 32.
// (R16) a memory tlp in the base window is multicast; group starts at index.

`include "mcg_defines.vh"

module mcg_config #(
  parameter ADDR_W = `MCG_ADDR_W
) (
  input  wire              clk_sys,
  input  wire              resetn,
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata_q,
  input  wire              cfg_load_active,
  input  wire              tlp_valid,
  input  wire              tlp_is_mem,
  input  wire              tlp_from_here,
  input  wire [63:0]       tlp_addr,
  output reg               fwd_valid_q,
  output reg               fwd_send_q,
  output reg  [5:0]        fwd_group_q,
  output reg               multicast_on_q
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  wire rst_n;
  assign rst_n = rst_sync_q;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg [5:0]  supported_group_count_q;
  reg        ecrc_regen_supported_q;
  reg [5:0]  enabled_group_count_q;
  reg [5:0]  group_index_lsb_q;
  reg [19:0] group_window_base_low_q;
  reg [31:0] group_window_base_high_q;
  reg [31:0] group_forward_mask_lo_q;
  reg [31:0] group_forward_mask_hi_q;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // group number sits at the index bit upward
  function [5:0] grp_of;
    input [63:0] a;
    input [5:0]  idx;
    reg   [63:0] sh;
    begin
      sh     = a >> idx;
      grp_of = sh[5:0];
    end
  endfunction

  // bits above the group field must match the base
  function win_hit;
    input [63:0] a;
    input [63:0] b;
    input [5:0]  idx;
    reg   [6:0]  top;
    reg   [63:0] am;
    reg   [63:0] bm;
    begin
      top     = {1'b0, idx} + 7'h06;
      am      = (top > 7'h3f) ? 64'h0 : (a >> top);
      bm      = (top > 7'h3f) ? 64'h0 : (b >> top);
      win_hit = (am == bm);
    end
  endfunction

  function hit_ofs;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] ofs;
    begin
      hit_ofs = (a == ofs);
    end
  endfunction

  // group field counts from zero, so the count itself is enabled
  function grp_in_count;
    input [5:0] g;
    input [5:0] cnt;
    begin
      grp_in_count = (g <= cnt);
    end
  endfunction

  function mask_pick;
    input [63:0] m;
    input [5:0]  g;
    begin
      mask_pick = m[g];
    end
  endfunction

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  wire wr_cap;
  wire wr_ctl;
  wire wr_blo;
  wire wr_bhi;
  wire wr_rlo;
  wire wr_rhi;

  assign wr_cap = reg_wr && hit_ofs(reg_addr, `MCG_OFS_CAP);
  assign wr_ctl = reg_wr && hit_ofs(reg_addr, `MCG_OFS_CTL);
  assign wr_blo = reg_wr && hit_ofs(reg_addr, `MCG_OFS_BASE_LO);
  assign wr_bhi = reg_wr && hit_ofs(reg_addr, `MCG_OFS_BASE_HI);
  assign wr_rlo = reg_wr && hit_ofs(reg_addr, `MCG_OFS_RCV_LO);
  assign wr_rhi = reg_wr && hit_ofs(reg_addr, `MCG_OFS_RCV_HI);

  // ----------------------------------------
  // capability
  // ----------------------------------------
  // locked fields: ordinary writes are dropped silently
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      supported_group_count_q <= `MCG_RST_MAXGRP; // see (R1)
    end else if (wr_cap && cfg_load_active) begin
      supported_group_count_q <= reg_wdata[`MCG_GRP_MSB:0]; // see (R2)
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ecrc_regen_supported_q <= `MCG_RST_ECRC; // see (R3)
    end else if (wr_cap && cfg_load_active) begin
      ecrc_regen_supported_q <= reg_wdata[`MCG_ECRC_BIT]; // see (R3)
    end
  end

  // ----------------------------------------
  // control
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enabled_group_count_q <= `MCG_RST_NUMGRP;
    end else if (wr_ctl) begin
      enabled_group_count_q <= reg_wdata[`MCG_GRP_MSB:0]; // see (R5)
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      multicast_on_q <= `MCG_RST_ON; // see (R4)
    end else if (wr_ctl) begin
      multicast_on_q <= reg_wdata[`MCG_ON_BIT]; // see (R4)
    end
  end

  // ----------------------------------------
  // window base
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      group_index_lsb_q <= `MCG_RST_IDX;
    end else if (wr_blo) begin
      group_index_lsb_q <= reg_wdata[`MCG_GRP_MSB:0]; // see (R7)
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      group_window_base_low_q <= `MCG_RST_BASE_LO;
    end else if (wr_blo) begin
      group_window_base_low_q <= reg_wdata[31:`MCG_BASE_LO_LSB]; // see (R9)
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      group_window_base_high_q <= `MCG_RST_WORD;
    end else if (wr_bhi) begin
      group_window_base_high_q <= reg_wdata; // see (R10)
    end
  end

  // ----------------------------------------
  // receive masks
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      group_forward_mask_lo_q <= `MCG_RST_WORD;
    end else if (wr_rlo) begin
      group_forward_mask_lo_q <= reg_wdata; // see (R12)
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      group_forward_mask_hi_q <= `MCG_RST_WORD;
    end else if (wr_rhi) begin
      group_forward_mask_hi_q <= reg_wdata; // see (R15)
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  reg [31:0] rdata_d;

  always @* begin
    rdata_d = `MCG_RST_WORD;
    case (reg_addr)
      `MCG_OFS_CAP: begin
        rdata_d[`MCG_GRP_MSB:0] = supported_group_count_q;
        rdata_d[`MCG_ECRC_BIT]  = ecrc_regen_supported_q;
      end
      `MCG_OFS_CTL: begin
        rdata_d[`MCG_GRP_MSB:0] = enabled_group_count_q;
        rdata_d[`MCG_ON_BIT]    = multicast_on_q;
      end
      `MCG_OFS_BASE_LO: begin
        rdata_d[`MCG_GRP_MSB:0]      = group_index_lsb_q;
        rdata_d[31:`MCG_BASE_LO_LSB] = group_window_base_low_q; // see (R9)
      end
      `MCG_OFS_BASE_HI: begin
        rdata_d = group_window_base_high_q;
      end
      `MCG_OFS_RCV_LO: begin
        rdata_d = group_forward_mask_lo_q;
      end
      `MCG_OFS_RCV_HI: begin
        rdata_d = group_forward_mask_hi_q;
      end
      default: begin
        rdata_d = `MCG_RST_WORD;
      end
    endcase
  end

  // data stands one cycle only; zero otherwise
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= `MCG_RST_WORD;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end else begin
      reg_rdata_q <= `MCG_RST_WORD;
    end
  end

  // ----------------------------------------
  // forwarding decision
  // ----------------------------------------
  wire [63:0] base_addr;
  wire [63:0] mask_all;
  wire [5:0]  grp;
  wire        in_window;
  wire        grp_enabled;
  wire        mask_bit;
  wire        send_d;

  assign base_addr = {group_window_base_high_q,
                      group_window_base_low_q,
                      12'h000}; // see (R10)
  assign mask_all  = {group_forward_mask_hi_q,
                      group_forward_mask_lo_q}; // see (R15)

  // relies on software keeping low base bits clear
  assign grp       = grp_of(tlp_addr, group_index_lsb_q); // see (R16)
  assign in_window = tlp_is_mem &&
                     win_hit(tlp_addr, base_addr,
                             group_index_lsb_q); // see (R16) (R11)

  // ----------------------------------------
  // mask lookup
  // ----------------------------------------
  // bits above the enabled count never forward
  assign grp_enabled = grp_in_count(grp,
                                    enabled_group_count_q); // see (R14) (R5)
  assign mask_bit    = mask_pick(mask_all, grp); // see (R12)

  assign send_d = tlp_valid && multicast_on_q && in_window &&
                  grp_enabled && mask_bit &&
                  !tlp_from_here; // see (R13) (R4)

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  // one decision per offered tlp, one cycle later
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fwd_valid_q <= 1'b0;
    end else begin
      fwd_valid_q <= tlp_valid;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fwd_send_q <= 1'b0;
    end else begin
      fwd_send_q <= send_d; // see (R13)
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fwd_group_q <= 6'h00;
    end else begin
      fwd_group_q <= tlp_valid ? grp : 6'h00;
    end
  end

endmodule // mcg_config

// ===== mcg_config_test.sv
module mcg_config_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys, resetn, reg_wr, reg_rd, cfg_load_active;
  logic        tlp_valid, tlp_is_mem, tlp_from_here;
  logic        fwd_valid_q, fwd_send_q, multicast_on_q;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q;
  logic [63:0] tlp_addr;
  logic [5:0]  fwd_group_q;
  int          n_mismatch, n_checks;
  mcg_config mcg_config_inst (.*);
  mcg_fabric mcg_fabric_inst (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task stop_test;
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk({32'h0, reg_rdata_q}, {32'h0, e});
  endtask
  task wrd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    wr(a, d);
    rd(a, e);
  endtask
  task tx(input logic [63:0] a, input logic m, h, s, input logic [5:0] g);
    mcg_fabric_inst.send(a, m, h);
    #1 chk({fwd_valid_q, fwd_send_q, fwd_group_q}, {1'b1, s, g});
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task t_reset_values;
    rd(12'h334, 32'h0000801f);
    rd(12'h336, 32'h0);
    rd(12'h338, 32'h0);
    rd(12'h33c, 32'h0);
    rd(12'h340, 32'h0);
    rd(12'h330, 32'h0);
  endtask
  task t_cap_lock;
    wrd(12'h334, 32'h0000003f, 32'h0000801f);
    @(posedge clk_sys) cfg_load_active <= 1'b1;
    wrd(12'h334, 32'hffffffff, 32'h0000803f);
    @(posedge clk_sys) cfg_load_active <= 1'b0;
    wrd(12'h334, 32'h0, 32'h0000803f);
  endtask
  task t_fields;
    wrd(12'h338, 32'hffffffff, 32'hfffff03f);
    wrd(12'h33c, 32'ha5a5a5a5, 32'ha5a5a5a5);
    wrd(12'h340, 32'h5a5a5a5a, 32'h5a5a5a5a);
    wrd(12'h336, 32'hffffffff, 32'h0000803f);
  endtask
  task t_forward;
    wr(12'h338, 32'h0100000c);
    wr(12'h33c, 32'h1);
    wr(12'h340, 32'h2a);
    wr(12'h344, 32'h1);
    wr(12'h336, 32'h8003);
    for (int g = 0; g < 6; g++)
      tx({40'h1_01, 6'h00, 6'(g), 12'h000}, 1, 0,
         g == 1 || g == 3, 6'(g));
    tx(64'h1_01001000, 1, 1, 0, 6'h01);
    tx(64'h1_01001000, 0, 0, 0, 6'h01);
    tx(64'h2_01001000, 1, 0, 0, 6'h01);
    wr(12'h336, 32'h803f);
    tx(64'h1_01020000, 1, 0, 1, 6'h20);
    tx(64'h1_01021000, 1, 0, 0, 6'h21);
    wr(12'h338, 32'h01000010);
    tx(64'h1_01030000, 1, 0, 1, 6'h03);
    wr(12'h336, 32'h003f);
    tx(64'h1_01030000, 1, 0, 0, 6'h03);
  endtask
  initial begin
    {resetn, reg_wr, reg_rd, cfg_load_active} = 4'h0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset_values;
    t_cap_lock;
    t_fields;
    t_forward;
    stop_test;
  end
  initial begin
    #20000;
    n_mismatch++;
    stop_test;
  end
endmodule // mcg_config_test
bind mcg_config mcg_props #(.ADDR_W(ADDR_W)) mcg_props_inst (.*);

// ===== mcg_defines.vh
`ifndef MCG_DEFINES_VH
`define MCG_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MCG_ADDR_W          12
`define MCG_OFS_CAP         12'h334
`define MCG_OFS_CTL         12'h336
`define MCG_OFS_BASE_LO     12'h338
`define MCG_OFS_BASE_HI     12'h33c
`define MCG_OFS_RCV_LO      12'h340
`define MCG_OFS_RCV_HI      12'h344

// ----------------------------------------
// field positions
// ----------------------------------------
`define MCG_GRP_MSB         5
`define MCG_GRP_W           6
`define MCG_ECRC_BIT        15
`define MCG_ON_BIT          15
`define MCG_BASE_LO_LSB     12
`define MCG_ADDR_SPLIT      32

// ----------------------------------------
// reset values
// ----------------------------------------
`define MCG_RST_MAXGRP      6'h1f
`define MCG_FULL_MAXGRP     6'h3f
`define MCG_RST_ECRC        1'h1
`define MCG_RST_NUMGRP      6'h00
`define MCG_RST_ON          1'h0
`define MCG_RST_IDX         6'h00
`define MCG_RST_BASE_LO     20'h00000
`define MCG_RST_WORD        32'h00000000

`endif

// ===== mcg_fabric.sv
module mcg_fabric (
  input  wire         clk_sys,
  output logic        tlp_valid,
  output logic        tlp_is_mem,
  output logic        tlp_from_here,
  output logic [63:0] tlp_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {tlp_valid, tlp_is_mem, tlp_from_here, tlp_addr} = '0;
  // one tlp per pulse; idle bus shows inverted junk, not a stale copy
  task automatic send(input logic [63:0] a, input logic m, input logic h);
    @(posedge clk_sys);
    {tlp_valid, tlp_is_mem, tlp_from_here, tlp_addr} <= {1'b1, m, h, a};
    @(posedge clk_sys);
    {tlp_valid, tlp_is_mem, tlp_from_here, tlp_addr} <= {1'b0, ~m, ~h, ~a};
  endtask
endmodule // mcg_fabric

// ===== mcg_props.sv
// ------------------------------
// port checks for mcg_config
// ------------------------------
module mcg_props #(
  parameter ADDR_W = 12
) (
  input wire              clk_sys,
  input wire              resetn,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [31:0]       reg_wdata,
  input wire              reg_wr,
  input wire              reg_rd,
  input wire [31:0]       reg_rdata_q,
  input wire              cfg_load_active,
  input wire              tlp_valid,
  input wire              tlp_is_mem,
  input wire              tlp_from_here,
  input wire [63:0]       tlp_addr,
  input wire              fwd_valid_q,
  input wire              fwd_send_q,
  input wire [5:0]        fwd_group_q,
  input wire              multicast_on_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_ctl_wr; reg_wr && reg_addr == 12'h336; endsequence
  sequence s_ctl_rd; reg_rd && reg_addr == 12'h336; endsequence
  chk_fwd_answer: assert property (tlp_valid |=> fwd_valid_q)
    else $error("tlp got no answer");
  chk_fwd_idle: assert property (!tlp_valid |=> !fwd_valid_q &&
    !fwd_send_q && fwd_group_q == 6'h00) else $error("answer without tlp");
  chk_send_cause: assert property (fwd_send_q |->
    $past(multicast_on_q) && $past(tlp_is_mem) && !$past(tlp_from_here))
    else $error("send without cause");
  chk_on_write: assert property (s_ctl_wr |=>
    multicast_on_q == $past(reg_wdata[15])) else $error("enable not written");
  chk_on_hold: assert property (!reg_wr |=> $stable(multicast_on_q))
    else $error("enable moved");
  chk_ctl_read: assert property (s_ctl_rd |=>
    reg_rdata_q[15] == multicast_on_q && reg_rdata_q[31:16] == 16'h0 &&
    reg_rdata_q[14:6] == 9'h000) else $error("control read bad");
  chk_rd_stands: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
    else $error("read data lingers");
  chk_base_rsvd: assert property (reg_rd && reg_addr == 12'h338 |=>
    reg_rdata_q[11:6] == 6'h00) else $error("base reserved set");
endmodule // mcg_props
